// *** verilog/scc_pkg.sv ***
// Shared constants for the sensor conditioner register bank
`default_nettype none

package scc_pkg;

    // ************************************************************
    // Memory map
    // ************************************************************
    localparam int unsigned NV_BYTES = 272;       // Array size
    localparam int unsigned NV_PAGE = 16;         // Page size
    localparam logic [8:0] ADDR_GPM_END = 9'h07F; // General memory top
    localparam logic [8:0] ADDR_CTRL0 = 9'h080;   // Device config
    localparam logic [8:0] ADDR_CTRL6 = 9'h086;   // Volatile setup
    localparam logic [8:0] ADDR_STATUS = 9'h087;  // Conversion status
    localparam logic [8:0] ADDR_RSV_END = 9'h08F; // Last reserved reg
    localparam logic [8:0] ADDR_T1_BASE = 9'h090; // Table one start
    localparam logic [8:0] ADDR_T1_END = 9'h0CF;  // Table one end
    localparam logic [8:0] ADDR_T2_BASE = 9'h0D0; // Table two start
    localparam logic [8:0] ADDR_T2_END = 9'h10F;  // Table two end

    // ************************************************************
    // Control register indices and fields
    // ************************************************************
    localparam logic [2:0] IDX_CFG = 3'h0;      // Device config
    localparam logic [2:0] IDX_T1D = 3'h1;      // Table one direct
    localparam logic [2:0] IDX_T2D = 3'h2;      // Table two direct
    localparam logic [2:0] IDX_G2D = 3'h4;      // Gen two direct
    localparam logic [2:0] IDX_PSET = 3'h5;     // Persistent setup
    localparam logic [2:0] IDX_VSET = 3'h6;     // Volatile setup
    localparam int unsigned B_LOCK_LO = 0;      // lock_sel_lo
    localparam int unsigned B_LOCK_HI = 1;      // lock_sel_hi
    localparam int unsigned B_VREF = 2;         // vref_pin_dir
    localparam int unsigned B_CONV_SEL = 3;     // conv_input_sel
    localparam int unsigned B_DEBOUNCE = 4;     // conv_debounce_disable
    localparam int unsigned B_PERSIST = 5;      // shadow_persist_sel
    localparam int unsigned B_GEN1 = 6;         // gen_one_polarity
    localparam int unsigned B_GEN2 = 7;         // gen_two_polarity
    localparam logic [7:0] DIRECT_MASK = 8'h3F; // Reserved bits 7:6
    localparam logic [7:0] CTRL6_RESET = 8'h00; // Volatile setup reset
    localparam logic [7:0] STATUS_RESET = 8'h00; // Status reset
    localparam logic [7:0] NV_FACTORY = 8'h00;  // Factory cell value

    // ************************************************************
    // Lock field codes
    // ************************************************************
    localparam logic [1:0] LOCK_NONE = 2'h0; // Nothing locked
    localparam logic [1:0] LOCK_GPM = 2'h1;  // General memory
    localparam logic [1:0] LOCK_T1 = 2'h2;   // Plus table one
    localparam logic [1:0] LOCK_ALL = 2'h3;  // Plus table two

    // ************************************************************
    // Timing and conversion
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;   // 100 MHz
    localparam int unsigned NV_WRITE_TIME_MS = 5; // Typical cycle
    localparam int unsigned NV_WRITE_MAX_MS = 10; // Never longer
    localparam int unsigned NV_WRITE_CYC =
        NV_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 20;         // Holds 500000
    localparam logic [2:0] FILTER_AGREE = 3'h4;   // Matching runs
    localparam int unsigned IDX_MSB = 7;          // Table index top
    localparam int unsigned IDX_LSB = 2;          // Table index bottom

    typedef enum logic [1:0]
    {
        SCC_ST_LOAD, // Power-up copy from cells
        SCC_ST_IDLE, // Accepting accesses
        SCC_ST_NVWR  // Self-timed write running
    } scc_state_e;

endpackage

`default_nettype wire

// *** verilog/scc_conv_filter.sv ***
// Conversion result debounce filter feeding the status register
`timescale 1ns/1ps
`default_nettype none

module scc_conv_filter
(
    input wire logic i_ref_clk,          // System clock
    input wire logic i_srst,             // Sync reset, high
    input wire logic i_conv_done,        // Conversion finished
    input wire logic [7:0] i_conv_result, // Converter output
    input wire logic i_debounce_disable, // Pass every result
    output logic [7:0] o_status,         // Filtered result
    output logic o_status_upd            // Status updated pulse
);

    // ************************************************************
    // Agreement tracking
    // ************************************************************
    logic [5:0] last_msb_ff; // Upper bits of previous result
    logic [2:0] agree_ff;    // Consecutive matching count
    logic [2:0] nxt_agree;   // Count including this result
    logic hit;               // Upper bits match previous

    always_comb
    begin
        hit = i_conv_result[7:2] == last_msb_ff;
        nxt_agree = hit ? agree_ff + 3'h1 : 3'h1;
    end

    // Count runs; a mismatch restarts the run at one
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            last_msb_ff <= 6'h00;
            agree_ff <= 3'h0;
        end
        else if (i_conv_done)
        begin
            last_msb_ff <= i_conv_result[7:2];
            // Restart after a full run so the count never overflows
            agree_ff <= (nxt_agree == scc_pkg::FILTER_AGREE) ?
                3'h0 : nxt_agree;
        end
    end

    // ************************************************************
    // Status update
    // ************************************************************
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_status <= scc_pkg::STATUS_RESET;
            o_status_upd <= 1'b0;
        end
        else if (i_conv_done &&
            (i_debounce_disable ||
             nxt_agree == scc_pkg::FILTER_AGREE))
        begin
            o_status <= i_conv_result;
            o_status_upd <= 1'b1;
        end
        else
        begin
            o_status_upd <= 1'b0;
        end
    end

endmodule // scc_conv_filter

`default_nettype wire

// *** verilog/scc_config_regs.sv ***
// Control, status and nonvolatile array of the sensor conditioner
`timescale 1ns/1ps
`default_nettype none

module scc_config_regs
#(
    parameter int unsigned P_NV_WRITE_CYC = scc_pkg::NV_WRITE_CYC
)
(
    input wire logic i_ref_clk,          // System clock
    input wire logic i_srst,             // Sync power-up reset
    input wire logic i_factory_init,     // Erase cells to zero
    input wire logic i_wr_guard_n,       // Write guard pin, low
    input wire logic i_wr_stb,           // Byte write strobe
    input wire logic i_rd_stb,           // Byte read strobe
    input wire logic [8:0] i_addr,       // Byte address
    input wire logic [7:0] i_wdata,      // Write byte
    input wire logic i_stop,             // Stop ends write sequence
    input wire logic i_conv_done,        // Conversion done pulse
    input wire logic [7:0] i_conv_result, // Converter result
    output logic [7:0] o_rdata,          // Read byte
    output logic o_rvalid,               // Read byte valid pulse
    output logic o_wr_refused,           // Write dropped pulse
    output logic o_addr_ack_en,          // Bus address may be acked
    output logic o_vref_out_en,          // Drive reference pin
    output logic o_conv_ext_sel,         // Converter uses sense pin
    output logic o_gen_one_sink,         // Generator one sinks
    output logic o_gen_two_sink,         // Generator two sinks
    output logic [7:0] o_dac_one_code,   // Generator one code
    output logic [7:0] o_dac_two_code    // Generator two code
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] nv_mem_ff [0:scc_pkg::NV_BYTES-1]; // Cell array
    logic [7:0] ctrl_ff [0:6];         // Volatile control copies
    scc_pkg::scc_state_e state_ff;     // Sequencer state
    logic [scc_pkg::TIMER_W-1:0] timer_ff; // Write cycle timer
    logic nv_dirty_ff;                 // Cells changed this sequence
    logic [7:0] status;                // Filtered conversion result
    logic status_upd;                  // Status changed pulse

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Lock field against address; registers 80h-8Fh never locked
    function automatic logic is_locked(input logic [8:0] addr,
                                       input logic [1:0] lock);
        logic general_memory;
        logic t1;
        logic t2;
        general_memory = addr <= scc_pkg::ADDR_GPM_END;
        t1 = addr >= scc_pkg::ADDR_T1_BASE &&
             addr <= scc_pkg::ADDR_T1_END;
        t2 = addr >= scc_pkg::ADDR_T2_BASE &&
             addr <= scc_pkg::ADDR_T2_END;
        unique case (lock)
            scc_pkg::LOCK_NONE: is_locked = 1'b0;
            scc_pkg::LOCK_GPM: is_locked = general_memory;
            scc_pkg::LOCK_T1: is_locked = general_memory || t1;
            scc_pkg::LOCK_ALL: is_locked = general_memory || t1 || t2;
        endcase
    endfunction

    // Address falls in the control block 80h-86h
    function automatic logic is_ctrl(input logic [8:0] addr);
        is_ctrl = addr >= scc_pkg::ADDR_CTRL0 &&
                  addr <= scc_pkg::ADDR_CTRL6;
    endfunction

    // Plain array byte outside the register block
    function automatic logic is_array(input logic [8:0] addr);
        is_array = addr <= scc_pkg::ADDR_GPM_END ||
            (addr >= scc_pkg::ADDR_T1_BASE &&
             addr <= scc_pkg::ADDR_T2_END);
    endfunction

    // ************************************************************
    // Write qualification
    // ************************************************************
    logic idle;          // Sequencer idle
    logic [1:0] lock;    // Current lock field
    logic [2:0] cidx;    // Control register index
    logic persist;       // Regs 1-4 go to cells too
    logic wr_ok;         // Write accepted
    logic wr_ctrl;       // Accepted write to control block
    logic wr_cell;       // Accepted write reaches the cells
    logic [7:0] wr_byte; // Write byte with reserved bits cleared

    always_comb
    begin
        idle = state_ff == scc_pkg::SCC_ST_IDLE;
        lock = {ctrl_ff[scc_pkg::IDX_CFG][scc_pkg::B_LOCK_HI],
                ctrl_ff[scc_pkg::IDX_CFG][scc_pkg::B_LOCK_LO]};
        cidx = i_addr[2:0];
        persist = ctrl_ff[scc_pkg::IDX_CFG][scc_pkg::B_PERSIST];
        // Guard pin overrides everything, then the lock field
        wr_ok = i_wr_stb && idle && i_wr_guard_n &&
            !is_locked(i_addr, lock) &&
            (is_array(i_addr) || is_ctrl(i_addr));
        wr_ctrl = wr_ok && is_ctrl(i_addr);
        // Config and persistent setup always reach their cells
        wr_cell = wr_ok && (is_array(i_addr) ||
            (is_ctrl(i_addr) && (cidx == scc_pkg::IDX_CFG ||
             cidx == scc_pkg::IDX_PSET ||
             (cidx >= scc_pkg::IDX_T1D &&
              cidx <= scc_pkg::IDX_G2D && persist))));
        // Direct table index registers carry two reserved bits
        if (wr_ctrl && (cidx == scc_pkg::IDX_T1D ||
            cidx == scc_pkg::IDX_T2D))
        begin
            wr_byte = i_wdata & scc_pkg::DIRECT_MASK;
        end
        else
        begin
            wr_byte = i_wdata;
        end
    end

    // ************************************************************
    // Cell array
    // ************************************************************
    // Cells are not touched by reset: they keep data over power-up
    always_ff @(posedge i_ref_clk)
    begin
        if (i_factory_init)
        begin
            for (int i = 0; i < scc_pkg::NV_BYTES; i++)
            begin
                nv_mem_ff[i] <= scc_pkg::NV_FACTORY;
            end
        end
        else if (wr_cell)
        begin
            nv_mem_ff[i_addr] <= wr_byte;
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    // Regs 0-5 copy their cells on load; reg 6 starts cleared
    generate
        for (genvar g = 0; g < 7; g++)
        begin : g_ctrl
            always_ff @(posedge i_ref_clk)
            begin
                if (i_srst)
                begin
                    ctrl_ff[g] <= scc_pkg::CTRL6_RESET;
                end
                else if (state_ff == scc_pkg::SCC_ST_LOAD &&
                         g != 6)
                begin
                    // Cell copy at power-up
                    ctrl_ff[g] <= nv_mem_ff[
                        scc_pkg::ADDR_CTRL0 + 9'(g)];
                end
                else if (wr_ctrl && cidx == 3'(g))
                begin
                    ctrl_ff[g] <= wr_byte;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Write cycle sequencer
    // ************************************************************
    // Dirty flag marks cell writes since the last stop
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            nv_dirty_ff <= 1'b0;
        end
        else if (wr_cell)
        begin
            nv_dirty_ff <= 1'b1;
        end
        else if (state_ff == scc_pkg::SCC_ST_NVWR)
        begin
            nv_dirty_ff <= 1'b0;
        end
    end

    // Load once after reset, then run a timed cycle on a stop after cell writes
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            state_ff <= scc_pkg::SCC_ST_LOAD;
            timer_ff <= '0;
        end
        else
        begin
            unique case (state_ff)
                scc_pkg::SCC_ST_LOAD:
                begin
                    state_ff <= scc_pkg::SCC_ST_IDLE;
                end
                scc_pkg::SCC_ST_IDLE:
                begin
                    // Only a stop after real cell writes costs time
                    if (i_stop && nv_dirty_ff)
                    begin
                        state_ff <= scc_pkg::SCC_ST_NVWR;
                        timer_ff <= '0;
                    end
                end
                scc_pkg::SCC_ST_NVWR:
                begin
                    if (timer_ff ==
                        scc_pkg::TIMER_W'(P_NV_WRITE_CYC - 1))
                    begin
                        state_ff <= scc_pkg::SCC_ST_IDLE;
                    end
                    timer_ff <= timer_ff + 1'b1;
                end
            endcase
        end
    end

    // Address acknowledge only while accesses can be served
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_addr_ack_en <= 1'b0;
            o_wr_refused <= 1'b0;
        end
        else
        begin
            // Host polls this instead of waiting out the cycle
            o_addr_ack_en <= state_ff == scc_pkg::SCC_ST_LOAD ||
                (idle && !(i_stop && nv_dirty_ff)) ||
                (state_ff == scc_pkg::SCC_ST_NVWR &&
                 timer_ff == scc_pkg::TIMER_W'(P_NV_WRITE_CYC - 1));
            o_wr_refused <= i_wr_stb && !wr_ok;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // Unmapped and reserved bytes read as zero
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_rd_stb && idle;
            if (i_rd_stb && idle)
            begin
                if (is_array(i_addr))
                begin
                    o_rdata <= nv_mem_ff[i_addr];
                end
                else if (is_ctrl(i_addr))
                begin
                    o_rdata <= ctrl_ff[cidx];
                end
                else if (i_addr == scc_pkg::ADDR_STATUS)
                begin
                    o_rdata <= status;
                end
                else
                begin
                    o_rdata <= 8'h00;
                end
            end
        end
    end

    // ************************************************************
    // Conversion status
    // ************************************************************
    scc_conv_filter u_filter
    (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_conv_done(i_conv_done),
        .i_conv_result(i_conv_result),
        .i_debounce_disable(
            ctrl_ff[scc_pkg::IDX_CFG][scc_pkg::B_DEBOUNCE]),
        .o_status(status),
        .o_status_upd(status_upd)
    );

    // ************************************************************
    // Analog steering
    // ************************************************************
    // Pin and generator controls follow the config register
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_vref_out_en <= 1'b0;
            o_conv_ext_sel <= 1'b0;
            o_gen_one_sink <= 1'b0;
            o_gen_two_sink <= 1'b0;
        end
        else
        begin
            o_vref_out_en <=
                !ctrl_ff[scc_pkg::IDX_CFG][scc_pkg::B_VREF];
            o_conv_ext_sel <=
                ctrl_ff[scc_pkg::IDX_CFG][scc_pkg::B_CONV_SEL];
            o_gen_one_sink <=
                ctrl_ff[scc_pkg::IDX_CFG][scc_pkg::B_GEN1];
            o_gen_two_sink <=
                ctrl_ff[scc_pkg::IDX_CFG][scc_pkg::B_GEN2];
        end
    end

    // Table lookup; refreshed every cycle so table edits show up
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_dac_one_code <= 8'h00;
            o_dac_two_code <= 8'h00;
        end
        else
        begin
            o_dac_one_code <= nv_mem_ff[scc_pkg::ADDR_T1_BASE +
                {3'h0, status[scc_pkg::IDX_MSB:scc_pkg::IDX_LSB]}];
            o_dac_two_code <= nv_mem_ff[scc_pkg::ADDR_T2_BASE +
                {3'h0, status[scc_pkg::IDX_MSB:scc_pkg::IDX_LSB]}];
        end
    end

endmodule // scc_config_regs

`default_nettype wire

// *** sim/scc_monitor.sv ***
// Assertion checker bound to the sensor conditioner register bank
`timescale 1ns/1ps
`default_nettype none

module scc_monitor
#(
    parameter int unsigned P_NV_WRITE_CYC = 20 // Busy span
)
(
    input wire logic i_ref_clk, // Clock
    input wire logic i_srst, // Reset
    input wire logic i_wr_guard_n, // Guard pin
    input wire logic i_wr_stb, // Write strobe
    input wire logic i_rd_stb, // Read strobe
    input wire logic [8:0] i_addr, // Address
    input wire logic [7:0] i_wdata, // Write byte
    input wire logic i_stop, // Stop
    input wire logic o_rvalid, // Read valid
    input wire logic o_wr_refused, // Write dropped
    input wire logic o_addr_ack_en, // Idle hint
    input wire logic o_vref_out_en, // Ref driven
    input wire logic o_conv_ext_sel, // Sense input
    input wire logic o_gen_one_sink // Gen one sinks
);
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    logic idle_ok; // Access would be taken
    logic armed_ff; // Ack seen since reset
    logic [31:0] low_cnt_ff; // Cycles of withheld ack
    assign idle_ok = o_addr_ack_en && !i_stop;
    // Armed keeps the power-up load span out of the count
    always_ff @(posedge i_ref_clk)
    begin
        armed_ff <= !i_srst && (armed_ff || o_addr_ack_en);
        low_cnt_ff <= (i_srst || o_addr_ack_en) ? 32'h0 : low_cnt_ff + 32'h1;
    end
    sequence s_cfg_write;
        i_wr_stb && idle_ok && i_wr_guard_n && i_addr == 9'h080 ##2 1'b1;
    endsequence
    sequence s_withheld;
        !o_addr_ack_en [*8];
    endsequence
    AST_RD_ANSWER: assert property (i_rd_stb && idle_ok |=> o_rvalid)
        else $error("read strobe got no answer");
    AST_RD_BUSY: assert property (
        i_rd_stb && !o_addr_ack_en |=> !o_rvalid)
        else $error("read answered while busy");
    AST_GUARD: assert property (
        i_wr_stb && !i_wr_guard_n |=> o_wr_refused)
        else $error("write taken with guard low");
    AST_RSV_WR: assert property (
        i_wr_stb && i_addr >= 9'h087 && i_addr <= 9'h08F |=> o_wr_refused)
        else $error("status or reserved write taken");
    AST_CFG_OUT: assert property (s_cfg_write |->
        o_vref_out_en == !$past(i_wdata[2], 2)
        && o_conv_ext_sel == $past(i_wdata[3], 2)
        && o_gen_one_sink == $past(i_wdata[6], 2))
        else $error("config outputs do not follow write");
    AST_ACK_STOP: assert property ($fell(o_addr_ack_en) |-> $past(i_stop))
        else $error("ack withheld without stop");
    AST_BUSY_MIN: assert property ($fell(o_addr_ack_en) |-> s_withheld)
        else $error("write cycle too short");
    AST_BUSY_SPAN: assert property (
        $rose(o_addr_ack_en) && armed_ff |-> low_cnt_ff >= P_NV_WRITE_CYC - 1
        && low_cnt_ff <= P_NV_WRITE_CYC + 1)
        else $error("write cycle length wrong");
endmodule // scc_monitor

bind scc_config_regs scc_monitor #(.P_NV_WRITE_CYC(P_NV_WRITE_CYC)) scc_monitor_i
(
    .i_ref_clk, .i_srst, .i_wr_guard_n, .i_wr_stb, .i_rd_stb, .i_addr,
    .i_wdata, .i_stop, .o_rvalid, .o_wr_refused, .o_addr_ack_en,
    .o_vref_out_en, .o_conv_ext_sel, .o_gen_one_sink
);
`default_nettype wire

// *** sim/scc_host_model.sv ***
// Bus host model issuing byte accesses to the register bank
`timescale 1ns/1ps
`default_nettype none

module scc_host_model
(
    input wire logic i_ref_clk, // Clock
    input wire logic i_ack_en, // Device idle
    input wire logic i_rvalid, // Read valid
    input wire logic [7:0] i_rdata, // Read byte
    input wire logic i_refused, // Write dropped
    output logic o_wr_stb, // Write strobe
    output logic o_rd_stb, // Read strobe
    output logic [8:0] o_addr, // Address
    output logic [7:0] o_wdata, // Write byte
    output logic o_stop // Stop condition
);
    bit poll_mode = 1'b0; // Access without waiting out a write
    initial {o_wr_stb, o_rd_stb, o_stop, o_addr, o_wdata} = 20'h0;
    // Wait out a write cycle unless polling
    task automatic idle_wait();
        int n;
        n = 0;
        while (!poll_mode && !i_ack_en && n < 100)
        begin
            @(posedge i_ref_clk);
            n++;
        end
    endtask
    // One strobe; lines flip on release so stale values never linger
    task automatic put(input logic w, input logic [8:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic ok);
        idle_wait();
        @(posedge i_ref_clk);
        o_wr_stb <= w;
        o_rd_stb <= !w;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_ref_clk);
        {o_wr_stb, o_rd_stb} <= 2'h0;
        o_addr <= ~a;
        o_wdata <= ~d;
        #1;
        q = i_rdata;
        ok = w ? i_refused : i_rvalid;
    endtask
    // Stop ends a write sequence, then the write time is honoured unless polling
    task automatic stop();
        @(posedge i_ref_clk);
        o_stop <= 1'b1;
        @(posedge i_ref_clk);
        o_stop <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        idle_wait();
    endtask
endmodule // scc_host_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the sensor conditioner register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct {logic [8:0] a; logic [7:0] d, q; logic f;} scc_row_s;
    logic i_ref_clk = 1'b0, i_srst = 1'b1, i_factory_init = 1'b1;
    logic i_wr_guard_n = 1'b1, i_conv_done = 1'b0;
    logic [7:0] i_conv_result = 8'h00;
    logic i_wr_stb, i_rd_stb, i_stop, o_rvalid, o_wr_refused, o_gen_two_sink;
    logic o_addr_ack_en, o_vref_out_en, o_conv_ext_sel, o_gen_one_sink;
    logic [8:0] i_addr;
    logic [7:0] i_wdata, o_rdata, o_dac_one_code, o_dac_two_code;
    logic [8:0] tgt [3] = '{9'h000, 9'h0A0, 9'h0E0}; // Lock targets
    logic [7:0] prev [3] = '{8'h3C, 8'h00, 8'h00}; // Their contents
    int failures = 0;
    int cmp_count = 0;
    // Write then read back; refused ones keep the old byte
    scc_row_s rows [9] = '{'{9'h081, 8'h3F, 8'h3F, 1'b0},
        '{9'h083, 8'hA5, 8'hA5, 1'b0}, '{9'h086, 8'h5A, 8'h5A, 1'b0},
        '{9'h087, 8'h12, 8'h00, 1'b1}, '{9'h08A, 8'h55, 8'h00, 1'b1},
        '{9'h110, 8'h77, 8'h00, 1'b1}, '{9'h000, 8'hC3, 8'hC3, 1'b0},
        '{9'h0CF, 8'h11, 8'h11, 1'b0}, '{9'h10F, 8'h22, 8'h22, 1'b0}};
    // Contents expected after a second power-up
    scc_row_s post [6] = '{'{9'h086, 8'h0, 8'h00, 1'b1},
        '{9'h083, 8'h0, 8'h00, 1'b1}, '{9'h084, 8'h0, 8'h99, 1'b1},
        '{9'h085, 8'h0, 8'h6B, 1'b1}, '{9'h080, 8'h0, 8'h20, 1'b1},
        '{9'h000, 8'h0, 8'h3C, 1'b1}};
    scc_config_regs #(.P_NV_WRITE_CYC(20)) scc_config_regs_i (.*);
    scc_host_model scc_host_model_i (.i_ref_clk, .i_ack_en(o_addr_ack_en),
        .i_rvalid(o_rvalid), .i_rdata(o_rdata), .i_refused(o_wr_refused),
        .o_wr_stb(i_wr_stb), .o_rd_stb(i_rd_stb), .o_addr(i_addr),
        .o_wdata(i_wdata), .o_stop(i_stop));
    always #5 i_ref_clk = ~i_ref_clk;
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask
    task automatic test_done();
        $display("failures %0d cmp_count %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Access and compare flag, plus byte for answered reads
    task automatic acc(input logic w, input logic [8:0] a,
        input logic [7:0] d, input logic [7:0] q, input logic f);
        logic [7:0] got;
        logic ok;
        scc_host_model_i.put(w, a, d, got, ok);
        chk1(ok, f);
        if (!w && f)
            chk8(got, q);
    endtask
    task automatic do_reset();
        i_srst <= 1'b1;
        repeat (20) @(posedge i_ref_clk);
        {i_srst, i_factory_init} <= 2'h0;
        repeat (3) @(posedge i_ref_clk);
    endtask
    task automatic conv(input logic [7:0] r);
        @(posedge i_ref_clk);
        i_conv_done <= 1'b1;
        i_conv_result <= r;
        @(posedge i_ref_clk);
        i_conv_done <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
    endtask
    initial
    begin
        #100000;
        failures++;
        test_done();
    end
    initial
    begin
        do_reset();
        for (int k = 0; k < 7; k++)
            acc(1'b0, 9'h080 + 9'(k), 8'h00, 8'h00, 1'b1);
        chk1(o_vref_out_en, 1'b1);
        foreach (rows[k])
        begin
            acc(1'b1, rows[k].a, rows[k].d, 8'h00, rows[k].f);
            acc(1'b0, rows[k].a, 8'h00, rows[k].q, 1'b1);
        end
        acc(1'b1, 9'h085, 8'h6B, 8'h00, 1'b0);
        acc(1'b1, 9'h080, 8'h20, 8'h00, 1'b0);
        acc(1'b1, 9'h084, 8'h99, 8'h00, 1'b0);
        scc_host_model_i.stop();
        acc(1'b1, 9'h000, 8'h3C, 8'h00, 1'b0);
        scc_host_model_i.poll_mode = 1'b1;
        scc_host_model_i.stop();
        acc(1'b0, 9'h081, 8'h00, 8'h00, 1'b0);
        scc_host_model_i.poll_mode = 1'b0;
        scc_host_model_i.idle_wait();
        do_reset();
        foreach (post[k])
            acc(1'b0, post[k].a, 8'h00, post[k].q, 1'b1);
        for (int c = 0; c < 4; c++)
        begin
            acc(1'b1, 9'h080, 8'(c), 8'h00, 1'b0);
            for (int t = 0; t < 3; t++)
            begin
                acc(1'b1, tgt[t], 8'(16 * c + t), 8'h00, c > t);
                prev[t] = (c > t) ? prev[t] : 8'(16 * c + t);
                acc(1'b0, tgt[t], 8'h00, prev[t], 1'b1);
            end
        end
        acc(1'b1, 9'h080, 8'h00, 8'h00, 1'b0);
        @(posedge i_ref_clk) i_wr_guard_n <= 1'b0;
        acc(1'b1, 9'h081, 8'h0F, 8'h00, 1'b1);
        @(posedge i_ref_clk) i_wr_guard_n <= 1'b1;
        acc(1'b0, 9'h081, 8'h00, 8'h00, 1'b1);
        acc(1'b1, 9'h080, 8'hDC, 8'h00, 1'b0);
        acc(1'b1, 9'h0A4, 8'h5E, 8'h00, 1'b0);
        acc(1'b1, 9'h0E4, 8'hE5, 8'h00, 1'b0);
        chk1(o_conv_ext_sel, 1'b1);
        chk1(o_gen_one_sink, 1'b1);
        chk1(o_gen_two_sink, 1'b1);
        chk1(o_vref_out_en, 1'b0);
        conv(8'h53);
        acc(1'b0, 9'h087, 8'h00, 8'h53, 1'b1);
        chk8(o_dac_one_code, 8'h5E);
        chk8(o_dac_two_code, 8'hE5);
        acc(1'b1, 9'h080, 8'h00, 8'h00, 1'b0);
        for (int n = 0; n < 4; n++)
        begin
            acc(1'b0, 9'h087, 8'h00, 8'h53, 1'b1);
            conv(8'h40);
        end
        acc(1'b0, 9'h087, 8'h00, 8'h40, 1'b1);
        test_done();
    end
endmodule // tb
`default_nettype wire
